// ---- rtl/adc_link_pkg.sv ----
package adc_link_pkg;
  // ----------------------------------------------------------------
  // Bus addresses and codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_FOUR_CH   = 7'h34; // Four-channel part.
  localparam logic [6:0] ADDR_TWELVE_CH = 7'h35; // Twelve-channel part.
  localparam logic [4:0] HS_CODE_TOP    = 5'h01; // Top of 0000 1xxx.

  // ----------------------------------------------------------------
  // Field positions in the received data byte
  // ----------------------------------------------------------------
  localparam int BYTE_ROUTE  = 7; // 1 = setup, 0 = configuration.
  localparam int SU_REF_HI   = 6;
  localparam int SU_REF_LO   = 4;
  localparam int SU_CLK      = 3;
  localparam int SU_BIP      = 2;
  localparam int SU_CFG_KEEP = 1; // Low restores configuration.
  localparam int CF_SCAN_HI  = 6;
  localparam int CF_SCAN_LO  = 5;
  localparam int CF_CS_HI    = 4;
  localparam int CF_CS_LO    = 1;
  localparam int CF_KIND     = 0;

  // ----------------------------------------------------------------
  // Power-up values
  // ----------------------------------------------------------------
  localparam logic [2:0] REF_RST  = 3'h0;
  localparam logic       CLK_RST  = 1'b0;
  localparam logic       BIP_RST  = 1'b0;
  localparam logic [1:0] SCAN_RST = 2'h0;
  localparam logic [3:0] CS_RST   = 4'h0;
  localparam logic       KIND_RST = 1'b1;
  localparam logic [3:0] CS_FOUR_MASK = 4'h3; // Top two bits forced low.

  // ----------------------------------------------------------------
  // Bit counting within a byte and its acknowledge slot
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7; // Eighth data bit.
  localparam logic [3:0] BIT_ACK   = 4'h8; // Ninth clock pulse.
  localparam int         SYNC_STAGES = 2;

  // Session states of the link engine.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_WRITE  = 3'b010,
    ST_READ   = 3'b011,
    ST_IGNORE = 3'b100
  } link_state_t;
endpackage

// ---- rtl/adc_link_slave.sv ----
`timescale 1ns/10ps
// What this block and the bus master do
// R01 - Falling data with clock high starts transfer.
// R02 - Rising data with clock high ends transfer.
// R03 - Repeated start keeps session and speed mode.
// R04 - Receiver pulls data low through ninth pulse.
// R05 - Not-acknowledge leaves data released on ninth.
// R06 - Master retries later after missing acknowledge.
// R07 - Idle until start plus own address.
// R08 - Fixed address per channel-count variant.
// R09 - Address low bit gives transfer direction.
// R10 - Acknowledge own address for one clock.
// R11 - Fast timing from power-up.
// R12 - Speed code gets no-acknowledge, then high speed.
// R13 - Master then sends repeated start, address.
// R14 - Stop in high-speed mode reverts timing.
// R15 - Top bit routes byte to setup or configuration.
// R16 - One or two bytes, any order, acknowledged.
// R17 - Master ends write with stop or restart.
// R18 - Setup bits six to four: reference select.
// R19 - Setup bit two polarity, bit three clock.
// R20 - Setup bit zero is ignored.
// R21 - Configuration bits six, five: scan select.
// R22 - Configuration bit zero: input kind, default one.
// R23 - Setup bit one low restores configuration.
// R24 - Configuration bits four to one: channel.
// R25 - Four-channel part forces top channel bits low.
// R26 - Single-ended input forces unipolar operation.
// R27 - Data stable while clock high.
module adc_link_slave import adc_link_pkg::*; #(
  parameter logic FOUR_CHANNEL = 1'b1 // 1 = four-channel variant.
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            hs_mode_o,
  output logic [2:0]      ref_select_o,
  output logic            ext_clock_o,
  output logic            polarity_select_o,
  output logic            polarity_eff_o,
  output logic [1:0]      scan_select_o,
  output logic [3:0]      channel_select_o,
  output logic            input_kind_select_o
);
  localparam logic [6:0] OWN_ADDR =
    FOUR_CHANNEL ? ADDR_FOUR_CH : ADDR_TWELVE_CH;

  // ----------------------------------------------------------------
  // Start and stop detection on the main clock
  // ----------------------------------------------------------------
  logic scl_s;      // Synchronised bus clock level.
  logic sda_s;      // Synchronised bus data level.
  logic scl_q;      // Previous synchronised clock.
  logic scl_qq;     // Clock two samples back.
  logic sda_q;      // Previous synchronised data.
  logic start_q;    // One-cycle start pulse.
  logic stop_q;     // One-cycle stop pulse.
  logic next_start; // Start seen this cycle.
  logic next_stop;  // Stop seen this cycle.
  logic start_n;    // Active-low frame clear for the link side.
  logic stop_n;     // Active-low session end for the link side.

  // Both bus lines idle high, so the synchroniser resets high.
  level_sync #(.WIDTH(2), .RST_VAL(8'h03)) u_pin_sync (
    .clk_i  (mclk_i),
    .rstn_i (rstn_i),
    .d_i    ({scl_i, sda_i}),
    .q_o    ({scl_s, sda_s})
  );

  // Data edges while the clock stays high are the only control
  // signalling; any other data change is ordinary bit traffic.
  // The bus clock may run faster than the main clock, so two high
  // samples can come from different bits; three in a row cannot,
  // since one of three samples always lands in a low phase.
  always_comb begin
    next_start = scl_s & scl_q & scl_qq & sda_q & ~sda_s; // see R01, see R27
    next_stop  = scl_s & scl_q & scl_qq & ~sda_q & sda_s; // see R02, see R27
  end

  // Edge history and the registered pulses.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q   <= 1'b1;
      scl_qq  <= 1'b1;
      sda_q   <= 1'b1;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      scl_q   <= scl_s;
      scl_qq  <= scl_q;
      sda_q   <= sda_s;
      start_q <= next_start;
      stop_q  <= next_stop;
    end
  end

  // The pulses come from flops, so these clears are glitch free.
  // They rise and fall while the bus clock is high, well before the
  // next rising edge, which keeps the link flops out of recovery.
  assign start_n = ~start_q;
  assign stop_n  = rstn_i & ~stop_q;

  // ----------------------------------------------------------------
  // Link engine on the bus clock
  // ----------------------------------------------------------------
  link_state_t st;         // Session state.
  link_state_t next_st;    // Next session state.
  logic [3:0]  bitcnt;     // Bit slot within the byte.
  logic [3:0]  next_bitcnt;
  logic [6:0]  shift;      // Bits gathered so far, MSB first.
  logic [6:0]  next_shift;
  logic [7:0]  byte_in;    // Byte complete on the eighth bit.
  logic        ack_q;      // Acknowledge owed in the ninth slot.
  logic        next_ack;
  logic        hs_pend;    // Speed code taken, slot not yet over.
  logic        next_hs_pend;
  logic        hs_mode;    // High-speed timing in force.
  logic        next_hs_mode;
  logic [2:0]  ref_sel;    // Reference selection field.
  logic        ext_clk;    // External conversion clock select.
  logic        bip;        // Bipolar select.
  logic [1:0]  scan;       // Scan selection field.
  logic [3:0]  chan;       // Channel selection field.
  logic        kind;       // 1 = single-ended, 0 = differential.
  logic [2:0]  next_ref_sel;
  logic        next_ext_clk;
  logic        next_bip;
  logic [1:0]  next_scan;
  logic [3:0]  next_chan;
  logic        next_kind;

  // Byte decoding, acknowledge decision and register writes.
  always_comb begin
    byte_in      = {shift, sda_i};
    next_st      = st;
    next_bitcnt  = bitcnt;
    next_shift   = shift;
    next_ack     = ack_q;
    next_hs_pend = hs_pend;
    next_hs_mode = hs_mode;
    next_ref_sel = ref_sel;
    next_ext_clk = ext_clk;
    next_bip     = bip;
    next_scan    = scan;
    next_chan    = chan;
    next_kind    = kind;
    if (st == ST_IDLE) begin
      // Clock edges outside a started frame are not ours.
      next_bitcnt = BIT_FIRST; // see R07
    end else if (bitcnt == BIT_ACK) begin
      // Ninth pulse: the acknowledge slot ends here.
      next_bitcnt = BIT_FIRST;
      next_ack    = 1'b0;
      if (hs_pend) begin
        next_hs_mode = 1'b1; // see R12
        next_hs_pend = 1'b0;
      end
    end else begin
      next_bitcnt = bitcnt + 4'h1;
      next_shift  = byte_in[6:0];
      if (bitcnt == BIT_LAST) begin
        unique case (st)
          ST_ADDR: begin
            if (byte_in[7:1] == OWN_ADDR) begin
              next_ack = 1'b1; // see R08, see R10
              // Low bit 0 means the master writes.
              next_st = byte_in[0] ? ST_READ : ST_WRITE; // see R09
            end else if (byte_in[7:3] == HS_CODE_TOP) begin
              // No acknowledge; speed switches after the slot.
              next_hs_pend = 1'b1; // see R12, see R05
              next_st      = ST_IGNORE;
            end else begin
              next_st = ST_IGNORE; // see R07
            end
          end
          ST_WRITE: begin
            next_ack = 1'b1; // see R16, see R04
            if (byte_in[BYTE_ROUTE]) begin // see R15
              next_ref_sel = byte_in[SU_REF_HI:SU_REF_LO]; // see R18
              next_ext_clk = byte_in[SU_CLK]; // see R19
              next_bip     = byte_in[SU_BIP]; // see R19
              // Bit 0 is never looked at.
              if (!byte_in[SU_CFG_KEEP]) begin // see R20, see R23
                next_scan = SCAN_RST;
                next_chan = CS_RST;
                next_kind = KIND_RST;
              end
            end else begin
              next_scan = byte_in[CF_SCAN_HI:CF_SCAN_LO]; // see R21
              next_chan = byte_in[CF_CS_HI:CF_CS_LO];     // see R24
              if (FOUR_CHANNEL) begin
                next_chan = next_chan & CS_FOUR_MASK; // see R25
              end
              next_kind = byte_in[CF_KIND]; // see R22
            end
          end
          // Result delivery is outside this block; the line stays
          // released during reads and in foreign frames.
          ST_READ, ST_IGNORE: begin
            next_ack = 1'b0;
          end
          default: begin
            next_st = ST_IGNORE;
          end
        endcase
      end
    end
  end

  // A stop closes the session, a start opens address phase; stop
  // wins when both are low, and a power-up reset holds stop low.
  always_ff @(posedge scl_i or negedge stop_n or negedge start_n) begin
    if (!stop_n) begin
      st      <= ST_IDLE; // see R02
      bitcnt  <= BIT_FIRST;
      shift   <= 7'h00;
      ack_q   <= 1'b0;
      hs_pend <= 1'b0;
    end else if (!start_n) begin
      st      <= ST_ADDR; // see R01, see R03
      bitcnt  <= BIT_FIRST;
      shift   <= 7'h00;
      ack_q   <= 1'b0;
      hs_pend <= 1'b0;
    end else begin
      st      <= next_st;
      bitcnt  <= next_bitcnt;
      shift   <= next_shift;
      ack_q   <= next_ack;
      hs_pend <= next_hs_pend;
    end
  end

  // Speed mode survives a repeated start but not a stop.
  always_ff @(posedge scl_i or negedge stop_n) begin
    if (!stop_n) begin
      hs_mode <= 1'b0; // see R11, see R14, see R03
    end else begin
      hs_mode <= next_hs_mode;
    end
  end

  // Setup and configuration keep their values across frames.
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_sel <= REF_RST;
      ext_clk <= CLK_RST;
      bip     <= BIP_RST;
      scan    <= SCAN_RST;
      chan    <= CS_RST;
      kind    <= KIND_RST;
    end else begin
      ref_sel <= next_ref_sel;
      ext_clk <= next_ext_clk;
      bip     <= next_bip;
      scan    <= next_scan;
      chan    <= next_chan;
      kind    <= next_kind;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  logic sda_drv; // Pull-down enable, changed on falling clock.

  // Changing on the falling edge keeps the line stable while the
  // clock is high, so our own drive never forms a start or stop.
  always_ff @(negedge scl_i or negedge stop_n or negedge start_n) begin
    if (!stop_n) begin
      sda_drv <= 1'b0;
    end else if (!start_n) begin
      sda_drv <= 1'b0;
    end else begin
      sda_drv <= ack_q; // see R04, see R27
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_drv;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The fields are quasi-static: they change only on a write, and
  // their users must sample them between bus frames.
  assign ref_select_o        = ref_sel;
  assign ext_clock_o         = ext_clk;
  assign polarity_select_o   = bip;
  assign polarity_eff_o      = bip & ~kind; // see R26
  assign scan_select_o       = scan;
  assign channel_select_o    = chan;
  assign input_kind_select_o = kind;

  level_sync #(.WIDTH(1), .RST_VAL(8'h00)) u_hs_sync (
    .clk_i  (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (hs_mode),
    .q_o    (hs_mode_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (scl_s && scl_q && scl_qq && sda_q && !sda_s)
    |=> start_q) // see R01
    else $error("start condition not flagged");

  a_stop_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (scl_s && scl_q && scl_qq && !sda_q && sda_s)
    |=> stop_q && !start_q) // see R02
    else $error("stop condition not flagged");

  a_stop_ends_hs: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    stop_q |=> !hs_mode ##1 !hs_mode) // see R14
    else $error("speed mode kept after stop");

  a_addr_ack: assert property (@(posedge scl_i)
    disable iff (!stop_n || !start_n)
    (st == ST_ADDR && bitcnt == BIT_LAST && byte_in[7:1] == OWN_ADDR)
    |=> ack_q ##1 !ack_q) // see R10
    else $error("own address not acknowledged for one slot");

  a_rw_dir: assert property (@(posedge scl_i)
    disable iff (!stop_n || !start_n)
    (st == ST_ADDR && bitcnt == BIT_LAST && byte_in[7:1] == OWN_ADDR)
    |=> st == ($past(sda_i) ? ST_READ : ST_WRITE)) // see R09
    else $error("wrong direction after address");

  a_hs_nack: assert property (@(posedge scl_i)
    disable iff (!stop_n || !start_n)
    (st == ST_ADDR && bitcnt == BIT_LAST && byte_in[7:3] == HS_CODE_TOP)
    |=> !ack_q && !hs_mode ##1 hs_mode) // see R12
    else $error("speed code handling wrong");

  a_setup_route: assert property (@(posedge scl_i)
    disable iff (!stop_n || !start_n)
    (st == ST_WRITE && bitcnt == BIT_LAST && byte_in[BYTE_ROUTE])
    |=> ref_sel == $past(byte_in[SU_REF_HI:SU_REF_LO])
        && bip == $past(byte_in[SU_BIP])) // see R15
    else $error("setup byte not stored");

  a_cfg_restore: assert property (@(posedge scl_i)
    disable iff (!stop_n || !start_n)
    (st == ST_WRITE && bitcnt == BIT_LAST && byte_in[BYTE_ROUTE]
     && !byte_in[SU_CFG_KEEP])
    |=> chan == CS_RST && kind == KIND_RST && scan == SCAN_RST) // see R23
    else $error("configuration not restored");

  a_four_chan: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    FOUR_CHANNEL |-> chan[3:2] == 2'h0) // see R25
    else $error("top channel bits set on four-channel part");

  a_ack_hold: assert property (@(posedge scl_i)
    disable iff (!stop_n || !start_n)
    (bitcnt == BIT_ACK && ack_q) |-> sda_oe_o) // see R04
    else $error("acknowledge not driven on ninth pulse");
endmodule

// ---- rtl/level_sync.sv ----
`timescale 1ns/10ps
// Two-stage level synchroniser; the first stage feeds only the second.
module level_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;      // First stage, may go metastable.
  logic [WIDTH-1:0] next_meta; // Next value of the first stage.
  logic [WIDTH-1:0] next_q;    // Next value of the second stage.

  // ----------------------------------------------------------------
  // Stage shift
  // ----------------------------------------------------------------
  // The input moves one stage per clock.
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  // Both stages take the reset level without looking at the input.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RST_VAL[WIDTH-1:0];
      q_o  <= RST_VAL[WIDTH-1:0];
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule

// ---- testbench/adc_link_slave_bench.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Self-checking bench for the converter's serial slave front end.
// ----------------------------------------------------------------
module adc_link_slave_bench import adc_link_pkg::*;;
  logic       mclk_i;       // Main clock, 50 ns.
  logic       rstn_i;       // Asynchronous reset, active low.
  logic       scl;          // Bus clock from the master model.
  logic       sda_rel;      // Master's open-drain data.
  logic       sda_line;     // Resolved data line.
  logic       sda_out;      // Device pull value.
  logic       sda_oe;       // Device pulls data low.
  logic       hs_mode;      // High-speed timing in force.
  logic [2:0] ref_sel;      // Reference select field.
  logic       ext_clk;      // External conversion clock.
  logic       pol_sel;      // Polarity as written.
  logic       pol_eff;      // Polarity in effect.
  logic [1:0] scan_sel;     // Scan select field.
  logic [3:0] chan_sel;     // Channel select field.
  logic       kind_sel;     // Single-ended when high.
  int         n_mismatch;   // Failed comparisons.
  int         n_compared;   // All comparisons.

  // The data line has a pull-up; either party may only pull it low.
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);

  adc_link_slave #(.FOUR_CHANNEL(1'b1)) u_dut (
    .mclk_i              (mclk_i),
    .rstn_i              (rstn_i),
    .scl_i               (scl),
    .sda_i               (sda_line),
    .sda_o               (sda_out),
    .sda_oe_o            (sda_oe),
    .hs_mode_o           (hs_mode),
    .ref_select_o        (ref_sel),
    .ext_clock_o         (ext_clk),
    .polarity_select_o   (pol_sel),
    .polarity_eff_o      (pol_eff),
    .scan_select_o       (scan_sel),
    .channel_select_o    (chan_sel),
    .input_kind_select_o (kind_sel)
  );

  two_wire_master u_master (
    .scl_o     (scl),
    .sda_rel_o (sda_rel),
    .sda_i     (sda_line)
  );

  // Main clock toggles every half period.
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prints the counts, then the verdict, and ends the run.
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Case-equality compare so that an unknown never passes.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Expected field vector; a single-ended input forces unipolar.
  function automatic logic [13:0] fld(input logic hs, input logic [2:0] rf,
      input logic ex, input logic pl, input logic [1:0] sc,
      input logic [3:0] cs, input logic kd);
    return {hs, rf, ex, pl, pl & ~kd, sc, cs, kd};
  endfunction

  // Compares all control outputs away from the clock edge.
  task automatic chk(input logic [13:0] e);
    @(negedge mclk_i);
    check({2'h0, hs_mode, ref_sel, ext_clk, pol_sel, pol_eff, scan_sel,
           chan_sel, kind_sel}, {2'h0, e});
  endtask

  // Sends one byte and compares the acknowledge seen in slot nine.
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_master.send_byte(b, a);
    check({15'h0000, a}, {15'h0000, exp_ack});
  endtask

  // Bounded wait for the synchronised speed flag; a timeout ends the run.
  task automatic wait_hs(input logic exp);
    for (int i = 0; i < 20; i++) begin
      if (hs_mode === exp) break;
      @(negedge mclk_i);
    end
    check({15'h0000, hs_mode}, {15'h0000, exp});
    if (hs_mode !== exp) print_verdict();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rstn_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(fld(1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1));
    $display("test reset_values done");

    // Setup then configuration; top channel bits are forced low.
    u_master.start_cond();
    wr({ADDR_FOUR_CH, 1'b0}, 1'b1);
    wr(8'hDF, 1'b1);
    wr(8'h5E, 1'b1);
    u_master.stop_cond();
    chk(fld(1'b0, 3'h5, 1'b1, 1'b1, 2'h2, 4'h3, 1'b0));
    $display("test setup_config done");

    // Setup with bit one low restores configuration; bit zero is low here.
    u_master.start_cond();
    wr({ADDR_FOUR_CH, 1'b0}, 1'b1);
    wr(8'hA0, 1'b1);
    u_master.stop_cond();
    chk(fld(1'b0, 3'h2, 1'b0, 1'b0, 2'h0, 4'h0, 1'b1));
    // Configuration first, then setup, closed by a restart.
    u_master.start_cond();
    wr({ADDR_FOUR_CH, 1'b0}, 1'b1);
    wr(8'h33, 1'b1);
    wr(8'h87, 1'b1);
    u_master.restart_cond();
    u_master.stop_cond();
    chk(fld(1'b0, 3'h0, 1'b0, 1'b1, 2'h1, 4'h1, 1'b1));
    $display("test restore_order done");

    // Foreign address and read direction leave the fields alone.
    u_master.start_cond();
    wr({ADDR_TWELVE_CH, 1'b0}, 1'b0);
    wr(8'hA0, 1'b0);
    u_master.stop_cond();
    u_master.start_cond();
    wr({ADDR_FOUR_CH, 1'b1}, 1'b1);
    wr(8'hA0, 1'b0);
    u_master.stop_cond();
    chk(fld(1'b0, 3'h0, 1'b0, 1'b1, 2'h1, 4'h1, 1'b1));
    $display("test refused_frames done");

    // Every speed code is refused, sets high speed, and stop clears it.
    for (int c = 8; c < 16; c++) begin
      u_master.start_cond();
      wr(8'(c), 1'b0);
      wait_hs(1'b1);
      u_master.stop_cond();
      wait_hs(1'b0);
    end
    // Speed code, restart, write; restarts keep the speed mode.
    u_master.start_cond();
    wr(8'h0F, 1'b0);
    u_master.restart_cond();
    wr({ADDR_FOUR_CH, 1'b0}, 1'b1);
    wr(8'hE6, 1'b1);
    u_master.restart_cond();
    chk(fld(1'b1, 3'h6, 1'b0, 1'b1, 2'h1, 4'h1, 1'b1));
    u_master.stop_cond();
    wait_hs(1'b0);
    chk(fld(1'b0, 3'h6, 1'b0, 1'b1, 2'h1, 4'h1, 1'b1));
    $display("test speed_mode done");
    print_verdict();
  end
endmodule

// ---- testbench/two_wire_master.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Behavioural bus master: makes the bus clock and drives data open drain.
// ----------------------------------------------------------------
// The bus clock runs at 15 ns per bit inside a byte and stands high
// between frames. Start and stop edges are stretched so that the
// device, which sees them through synchronisers, can catch them.
module two_wire_master (
  output logic      scl_o,     // Bus clock, idle high.
  output logic      sda_rel_o, // 1 = data released to the pull-up.
  input  wire logic sda_i      // Resolved data line level.
);
  // Both lines idle high when nobody owns the bus.
  initial begin
    scl_o     = 1'b1;
    sda_rel_o = 1'b1;
  end

  // Data falls while the clock is high; called with both lines high.
  task automatic start_cond();
    #213;
    sda_rel_o = 1'b0;
    #200;
    scl_o = 1'b0;
    #200;
  endtask

  // A restart raises data with the clock low, then starts again.
  task automatic restart_cond();
    sda_rel_o = 1'b1;
    #100;
    scl_o = 1'b1;
    start_cond();
  endtask

  // Data rises while the clock is high; the frame ends here.
  task automatic stop_cond();
    sda_rel_o = 1'b0;
    #100;
    scl_o = 1'b1;
    #200;
    sda_rel_o = 1'b1;
    #200;
  endtask

  // Data moves only with the clock low, so it is stable while high.
  task automatic clock_bit(input logic v, output logic seen);
    #2;
    sda_rel_o = v;
    #5.5;
    scl_o = 1'b1;
    #1;
    seen = sda_i;
    #6.5;
    scl_o = 1'b0;
  endtask

  // Eight bits MSB first, then a released ninth slot read as acknowledge.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], seen);
    end
    clock_bit(1'b1, seen);
    ack = ~seen;
  endtask
endmodule
